// file: pam4_src_pkg.sv
package pam4_src_pkg;

  // ****************************************
  // apb register map
  // ****************************************
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] STATUS_OFS  = 12'h004;
  localparam logic [11:0] PAT_LEN_OFS = 12'h008;
  localparam logic [11:0] PAT_WR_OFS  = 12'h00C;

  // ****************************************
  // control field positions
  // ****************************************
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_MERGE_BIT  = 1;
  localparam int CTRL_POL_BIT    = 2;
  localparam int CTRL_SRC_BIT    = 3;
  localparam int CTRL_COMP_BIT   = 4;
  localparam int CTRL_GRAY_BIT   = 5;
  localparam int CTRL_LEN_LSB    = 8;
  localparam int CTRL_LEN_W      = 3;
  localparam int CTRL_LANE_LSB   = 12;
  localparam int CTRL_LANE_W     = 2;

  localparam int STAT_LOADING_BIT = 0;
  localparam int STAT_AVAIL_BIT   = 1;
  localparam int STAT_ACTIVE_BIT  = 2;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // ****************************************
  // generator lengths and taps
  // ****************************************
  localparam int PRNG_W = 31;

  typedef enum logic [2:0] {
    LEN7  = 3'h0,
    LEN9  = 3'h1,
    LEN10 = 3'h2,
    LEN11 = 3'h3,
    LEN15 = 3'h4,
    LEN20 = 3'h5,
    LEN23 = 3'h6,
    LEN31 = 3'h7
  } prng_len_t;

  // fibonacci taps, bit k set means stage k+1 fed back
  function automatic logic [PRNG_W-1:0] prng_taps(input logic [2:0] sel);
    unique case (sel)
      LEN7:    prng_taps = 31'h0000_0060;
      LEN9:    prng_taps = 31'h0000_0110;
      LEN10:   prng_taps = 31'h0000_0240;
      LEN11:   prng_taps = 31'h0000_0500;
      LEN15:   prng_taps = 31'h0000_6000;
      LEN20:   prng_taps = 31'h0009_0000;
      LEN23:   prng_taps = 31'h0042_0000;
      default: prng_taps = 31'h4800_0000;
    endcase
  endfunction

  // per-lane start states, all non-zero in every length
  function automatic logic [PRNG_W-1:0] lane_seed(input logic [1:0] lane);
    unique case (lane)
      2'h0:    lane_seed = 31'h7FFF_FFFF;
      2'h1:    lane_seed = 31'h5555_5555;
      2'h2:    lane_seed = 31'h3333_3333;
      default: lane_seed = 31'h0F0F_0F0F;
    endcase
  endfunction

  // symbol states, one-hot: idle, load, msb, lsb
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_MSB  = 4'b0100,
    ST_LSB  = 4'b1000
  } src_state_t;

endpackage

// file: pam4_test_pattern_source.sv
// Local design decisions: the APB slave port and the register addresses.
module pam4_test_pattern_source
  import pam4_src_pkg::*;
#(
  parameter int PAT_DEPTH = 1024,
  parameter int PAT_AW    = 10
) (
  // clock, reset, enable
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        CLK_EN_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // symbol stream
  output logic      [1:0]  LEVEL_O,
  output logic             LEVEL_VALID_O
);

// Operation
// [R1] four-level mode runs only while the dual-channel merge flag is set
// [R2] polarity: true means high level is one, inverted means high is zero
// [R3] source select chooses generator or stored user pattern
// [R4] maximal-length generator, lengths 7,9,10,11,15,20,23,31 selectable
// [R5] complement control inverts generator bits, independent of polarity and gray
// [R6] start state selectable per lane 0..3 to shift phases
// [R7] gray map 00-00, 01-01, 10-11, 11-10
// [R8] gray off passes symbols unchanged for both sources
// [R9] selecting user source loads pattern memory, loading flag held until done
// [R10] bits paired msb first; complement, polarity, gray, then level select
// [R11] setting changes restart generator at a symbol boundary only

  // ****************************************
  // registers
  // ****************************************
  logic [31:0]       ctrl_q, ctrl_d;
  logic [PAT_AW:0]   plen_q, plen_d;
  logic [PAT_AW-1:0] wptr_q, wptr_d;
  logic [PAT_AW-1:0] rptr_q, rptr_d;
  logic [PRNG_W-1:0] lfsr_q, lfsr_d;
  logic              hi_q, hi_d;
  logic              reload_q, reload_d;
  logic [1:0]        lvl_q, lvl_d;
  logic              vld_q, vld_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              ack_q, ack_d;
  src_state_t        st_q, st_d;
  logic              pat_mem [PAT_DEPTH];

  logic wr_acc, rd_acc, hit, raw_bit, run_ok, bit_c;
  logic [1:0] sym, gsym;

  // one wait state: read data is registered in the first access cycle, ready comes in the second
  assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I & ack_q & CLK_EN_I;
  assign rd_acc = PSEL_I & PENABLE_I & ~PWRITE_I & ~ack_q & CLK_EN_I;
  assign hit    = (PADDR_I == CTRL_OFS) | (PADDR_I == STATUS_OFS) |
                  (PADDR_I == PAT_LEN_OFS) | (PADDR_I == PAT_WR_OFS);
  assign PREADY_O  = ack_q;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;
  assign PRDATA_O  = rdata_q;
  assign LEVEL_O       = lvl_q;
  // gated so a pulse frozen by the enable is taken only once
  assign LEVEL_VALID_O = vld_q & CLK_EN_I;

  // mode is refused unless both channels are merged
  assign run_ok = ctrl_q[CTRL_ENABLE_BIT] & ctrl_q[CTRL_MERGE_BIT]; // [R1]

  // ****************************************
  // bus side
  // ****************************************
  always_comb begin
    ctrl_d   = ctrl_q;
    plen_d   = plen_q;
    wptr_d   = wptr_q;
    rdata_d  = rdata_q;
    reload_d = reload_q;
    ack_d    = PSEL_I & PENABLE_I & ~ack_q;
    if (wr_acc && PADDR_I == CTRL_OFS) begin
      ctrl_d   = PWDATA_I;
      // any change waits for the next symbol boundary
      reload_d = reload_q | (PWDATA_I != ctrl_q); // [R11]
    end
    if (wr_acc && PADDR_I == PAT_LEN_OFS) begin
      plen_d = PWDATA_I[PAT_AW:0];
      wptr_d = '0;
    end
    if (wr_acc && PADDR_I == PAT_WR_OFS) begin
      wptr_d = wptr_q + 1'b1;
    end
    if (st_q == ST_MSB || st_q == ST_LOAD || st_q == ST_IDLE) begin
      reload_d = reload_q & ~(st_q == ST_MSB) & ~(st_q == ST_LOAD);
      if (wr_acc && PADDR_I == CTRL_OFS && PWDATA_I != ctrl_q) begin
        reload_d = 1'b1;
      end
    end
    if (rd_acc) begin
      unique case (PADDR_I)
        CTRL_OFS:    rdata_d = ctrl_q;
        STATUS_OFS:  rdata_d = {29'h0, st_q == ST_MSB || st_q == ST_LSB, run_ok,
                                st_q == ST_LOAD}; // [R9]
        PAT_LEN_OFS: rdata_d = {{(31-PAT_AW){1'b0}}, plen_q};
        default:     rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      ctrl_q   <= CTRL_RST;
      plen_q   <= '0;
      wptr_q   <= '0;
      rdata_q  <= 32'h0000_0000;
      reload_q <= 1'b1;
      ack_q    <= 1'b0;
    end else if (CLK_EN_I) begin
      ctrl_q   <= ctrl_d;
      plen_q   <= plen_d;
      wptr_q   <= wptr_d;
      rdata_q  <= rdata_d;
      reload_q <= reload_d;
      ack_q    <= ack_d;
    end
  end

  // pattern memory has no reset, so it maps to block ram
  always_ff @(posedge SYS_CLK_I) begin
    if (CLK_EN_I && wr_acc && PADDR_I == PAT_WR_OFS) begin
      pat_mem[wptr_q] <= PWDATA_I[0];
    end
  end

  // ****************************************
  // symbol pipeline
  // ****************************************
  logic lfsr_fb;
  assign lfsr_fb = ^(lfsr_q & prng_taps(ctrl_q[CTRL_LEN_LSB +: CTRL_LEN_W])); // [R4]

  // pointer wraps at the loaded length; one bit wider so a full-depth pattern still wraps
  function automatic logic [PAT_AW-1:0] step_ptr(input logic [PAT_AW-1:0] ptr, input logic [PAT_AW:0] len);
    logic [PAT_AW:0] nxt;
    nxt      = {1'b0, ptr} + {{PAT_AW{1'b0}}, 1'b1};
    step_ptr = (nxt >= len) ? '0 : nxt[PAT_AW-1:0];
  endfunction

  always_comb begin
    raw_bit = ctrl_q[CTRL_SRC_BIT] ? pat_mem[rptr_q] : lfsr_q[0]; // [R3]
    bit_c   = raw_bit ^ (ctrl_q[CTRL_COMP_BIT] & ~ctrl_q[CTRL_SRC_BIT]); // [R5]
    bit_c   = bit_c ^ ctrl_q[CTRL_POL_BIT]; // [R2]
  end

  always_comb begin
    st_d   = st_q;
    lfsr_d = lfsr_q;
    rptr_d = rptr_q;
    hi_d   = hi_q;
    lvl_d  = lvl_q;
    vld_d  = 1'b0;
    sym    = {hi_q, bit_c}; // [R10]
    gsym   = ctrl_q[CTRL_GRAY_BIT] ? {sym[1], sym[1] ^ sym[0]} : sym; // [R7] [R8]
    unique case (st_q)
      ST_IDLE: begin
        if (run_ok) begin
          st_d = ctrl_q[CTRL_SRC_BIT] ? ST_LOAD : ST_MSB; // [R9]
          lfsr_d = lane_seed(ctrl_q[CTRL_LANE_LSB +: CTRL_LANE_W]); // [R6]
          rptr_d = '0;
        end
      end
      ST_LOAD: begin
        // pattern counted in once before playback, loading shown meanwhile
        rptr_d = step_ptr(rptr_q, plen_q);
        if (rptr_d == '0) begin
          st_d = ST_MSB;
        end
      end
      ST_MSB: begin
        if (!run_ok) begin
          st_d = ST_IDLE;
        end else if (reload_q) begin
          st_d   = ctrl_q[CTRL_SRC_BIT] ? ST_LOAD : ST_MSB; // [R11]
          lfsr_d = lane_seed(ctrl_q[CTRL_LANE_LSB +: CTRL_LANE_W]);
          rptr_d = '0;
        end else begin
          hi_d = bit_c;
          st_d = ST_LSB;
          // shift up, taps on the low stages: every length lives in the same low bits
          lfsr_d = {lfsr_q[PRNG_W-2:0], lfsr_fb}; // [R4]
          rptr_d = step_ptr(rptr_q, plen_q);
        end
      end
      ST_LSB: begin
        lvl_d  = gsym;
        vld_d  = 1'b1;
        st_d   = ST_MSB;
        lfsr_d = {lfsr_q[PRNG_W-2:0], lfsr_fb};
        rptr_d = step_ptr(rptr_q, plen_q);
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      st_q   <= ST_IDLE;
      lfsr_q <= '1;
      rptr_q <= '0;
      hi_q   <= 1'b0;
      lvl_q  <= 2'h0;
      vld_q  <= 1'b0;
    end else if (CLK_EN_I) begin
      st_q   <= st_d;
      lfsr_q <= lfsr_d;
      rptr_q <= rptr_d;
      hi_q   <= hi_d;
      lvl_q  <= lvl_d;
      vld_q  <= vld_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_pair;
    st_q == ST_MSB && run_ok && !reload_q && CLK_EN_I ##1 st_q == ST_LSB;
  endsequence

  AST_NO_MERGE: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [R1]
    !ctrl_q[CTRL_MERGE_BIT] && st_q != ST_LSB && CLK_EN_I |=> !vld_q)
    else $error("symbol while unmerged");

  AST_PAIR_OUT: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [R10]
    s_pair |-> (CLK_EN_I ##1 vld_q) or (!CLK_EN_I ##1 1'b1))
    else $error("pair not emitted");

  AST_GRAY: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [R7]
    st_q == ST_LSB && CLK_EN_I && ctrl_q[CTRL_GRAY_BIT] |=> lvl_q[0] == ($past(hi_q) ^ $past(bit_c)))
    else $error("gray map wrong");

  AST_PLAIN: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [R8]
    st_q == ST_LSB && CLK_EN_I && !ctrl_q[CTRL_GRAY_BIT] |=> lvl_q == {$past(hi_q), $past(bit_c)})
    else $error("plain map wrong");

  AST_POL: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [R2]
    ctrl_q[CTRL_SRC_BIT] |-> bit_c == (pat_mem[rptr_q] ^ ctrl_q[CTRL_POL_BIT]))
    else $error("polarity wrong");

  AST_COMP: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [R5]
    !ctrl_q[CTRL_SRC_BIT] |-> bit_c == (lfsr_q[0] ^ ctrl_q[CTRL_COMP_BIT] ^ ctrl_q[CTRL_POL_BIT]))
    else $error("complement wrong");

  AST_SEED: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [R6]
    st_q == ST_IDLE && run_ok && CLK_EN_I |=> lfsr_q == lane_seed($past(ctrl_q[CTRL_LANE_LSB +: CTRL_LANE_W])))
    else $error("seed wrong");

  AST_BOUNDARY: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [R11]
    st_q == ST_LSB && CLK_EN_I |=> st_q == ST_MSB)
    else $error("symbol cut");

  AST_LOAD: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [R9]
    st_q == ST_LOAD |-> !vld_q)
    else $error("output during load");

  AST_NONZERO: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [R4]
    lfsr_q != '0)
    else $error("generator locked");

endmodule

// file: pam4_level_sink.sv
module pam4_level_sink (
  // clock, reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // symbol stream
  input  wire logic [1:0] level_i,
  input  wire logic       valid_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // output stage
  // ****************************************
  // unbounded queue: bench empties it before each capture
  logic [1:0] sym_q[$];
  always @(posedge clk_i) begin
    if (rst_i) begin
      sym_q.delete();
    end else if (valid_i) begin
      sym_q.push_back(level_i);
    end
  end
endmodule

// file: test_pam4_test_pattern_source.sv
module test_pam4_test_pattern_source;
  import pam4_src_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // signals
  // ****************************************
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  level;
  logic        lvalid;
  logic [31:0] rd;
  logic        err;
  logic [1:0]  ref_q[$];
  int          errors = 0;
  int          num_checks = 0;

  always #20 clk = ~clk;

  pam4_test_pattern_source dut (.SYS_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(clk_en), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .LEVEL_O(level), .LEVEL_VALID_O(lvalid));
  pam4_level_sink sink (.clk_i(clk), .rst_i(rst), .level_i(level), .valid_i(lvalid));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until ready is seen high; read data and error taken at that same edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  // stop, let the pipe drain, then restart from the seed
  task automatic start(input logic [31:0] c);
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    repeat (4) @(posedge clk);
    sink.sym_q.delete();
    apb(1'b1, CTRL_OFS, c);
  endtask

  task automatic grab(input int n);
    for (int i = 0; i < 4 * n + 40 && sink.sym_q.size() < n; i++) @(posedge clk);
    check(32'(sink.sym_q.size() >= n), 32'h0000_0001);
  endtask

  function automatic logic [31:0] ctl(input int len, input logic [31:0] f);
    return f | 32'(len << CTRL_LEN_LSB) | 32'h0000_0003;
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_basic();
    check(prdata, 32'h0000_0000);
    check(32'(lvalid), 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    check(rd, 32'h0000_0000);
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    repeat (20) @(posedge clk);
    check(32'(sink.sym_q.size()), 32'h0000_0000);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    check(rd, 32'h0000_0000);
  endtask

  task automatic t_period();
    int nl[4] = '{7, 9, 10, 11};
    logic b[0:4095];
    int p;
    int ones;
    for (int k = 0; k < 4; k++) begin
      p = (1 << nl[k]) - 1;
      ones = 0;
      start(ctl(k, 0));
      grab(p);
      for (int i = 0; i < p; i++) begin
        b[2*i] = sink.sym_q[i][1];
        b[2*i+1] = sink.sym_q[i][0];
      end
      for (int i = 0; i < p; i++) begin
        ones += int'(b[i]);
        check(32'(b[i+p]), 32'(b[i]));
      end
      check(32'(ones), 32'(1 << (nl[k] - 1)));
    end
  endtask

  task automatic t_opts();
    logic [1:0] s;
    int         same;
    start(ctl(0, 0));
    grab(32);
    ref_q = sink.sym_q;
    for (int k = 0; k < 8; k++) begin
      start(ctl(0, 32'(k[0]) << CTRL_COMP_BIT | 32'(k[1]) << CTRL_POL_BIT | 32'(k[2]) << CTRL_GRAY_BIT));
      grab(32);
      for (int i = 0; i < 32; i++) begin
        s = ref_q[i] ^ {2{k[0] ^ k[1]}};
        check(32'(sink.sym_q[i]), 32'(k[2] ? {s[1], s[1] ^ s[0]} : s));
      end
    end
    start(ctl(0, 32'h0000_1000));
    grab(32);
    same = 1;
    for (int i = 0; i < 32; i++) if (sink.sym_q[i] !== ref_q[i]) same = 0;
    check(32'(same), 32'h0000_0000);
  endtask

  // enable low must hold every state, so the stream resumes exactly where it stopped
  task automatic t_freeze();
    int n;
    int same;
    start(ctl(0, 0));
    grab(8);
    clk_en <= 1'b0;
    @(posedge clk);
    n = sink.sym_q.size();
    repeat (20) @(posedge clk);
    check(32'(sink.sym_q.size()), 32'(n));
    clk_en <= 1'b1;
    grab(32);
    same = 1;
    for (int i = 0; i < 32; i++) if (sink.sym_q[i] !== ref_q[i]) same = 0;
    check(32'(same), 32'h0000_0001);
  endtask

  task automatic t_user();
    logic [7:0] pat = 8'hB2;
    apb(1'b1, PAT_LEN_OFS, 32'h0000_0008);
    for (int i = 7; i >= 0; i--) apb(1'b1, PAT_WR_OFS, 32'(pat[i]));
    start(ctl(0, 32'h0000_0008));
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    check(32'(rd[STAT_LOADING_BIT]), 32'h0000_0001);
    grab(8);
    for (int i = 0; i < 8; i++) check(32'(sink.sym_q[i]), 32'(pat[7-2*(i%4)-:2]));
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    check(32'(rd[STAT_LOADING_BIT]), 32'h0000_0000);
    check(32'(rd[STAT_ACTIVE_BIT]), 32'h0000_0001);
  endtask

  // ****************************************
  // sequence and verdict
  // ****************************************
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_basic();
    t_period();
    t_opts();
    t_freeze();
    t_user();
    test_done();
  end

  // roughly three times the expected run
  initial begin
    #1000000;
    errors++;
    test_done();
  end
endmodule
